// file: pkg/hctt_pkg.sv
// Purpose: shared constants and types for host cycle time-out supervision
// Assumes: 16-bit registers on a plain strobe port
// Notes: offsets are byte addresses
package hctt_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_IRQ_ENABLES = 16'h0a0c;
  localparam logic [15:0] ADDR_TIMEOUT_CTRL = 16'h0a0e;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0a0a;
  localparam logic [15:0] ADDR_GLOBAL_CTRL = 16'h0a02;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_IRQ_ENABLES = 16'h0000;
  localparam logic [15:0] RST_TIMEOUT_CTRL = 16'h0000;
  localparam logic [15:0] RST_IRQ_STATUS = 16'h0000;
  localparam logic [15:0] RST_GLOBAL_CTRL = 16'h0000;

  // ==========================================================
  // field positions
  localparam int BIT_TIMEOUT = 15;
  localparam int BIT_BLT_WR = 5;
  localparam int BIT_BLT_RD = 4;
  localparam int BIT_LB_WR = 3;
  localparam int BIT_LB_RD = 2;
  localparam int BIT_JF_WR = 1;
  localparam int BIT_RSVD = 0;
  localparam int BIT_IMMEDIATE = 7;
  localparam int TOV_MSB = 4;
  localparam int BIT_HOST_IE = 4;
  localparam logic [15:0] EVENT_MASK = 16'h803e;
  localparam logic [15:0] TOCTRL_MASK = 16'h009f;
  localparam logic [15:0] GLOBAL_MASK = 16'h0010;
  localparam logic [4:0] TOV_ALL_ONES = 5'h1f;

  // ==========================================================
  // timing: count clock is system clock divided by two
  localparam int COUNT_DIV = 2;

  typedef enum logic [2:0] {
    HCTT_JF_WR,
    HCTT_LB_WR,
    HCTT_LB_RD,
    HCTT_BLT_WR,
    HCTT_BLT_RD
  } hctt_target_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [2:0] target;
  } hctt_access_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } hctt_reg_req_t;

endpackage

// file: hdl/hctt_half_rate_div.sv
// Purpose: enable pulse at half the system clock rate
// Assumes: single clock domain
// Notes: pulse high every second cycle
`timescale 1ns/1ps
module hctt_half_rate_div (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // enable out
  output logic half_rate_count_clock
);

  logic phase;
  logic next_phase;

  always_comb begin
    next_phase = ~phase;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 1'b0;
      half_rate_count_clock <= 1'b0;
    end else begin
      phase <= next_phase;
      half_rate_count_clock <= next_phase;
    end
  end

endmodule

// file: hdl/hctt_stall_timer.sv
// Purpose: counts half-rate units of one stalled access
// Assumes: stall is a level that holds while the access waits
// Notes: restarts at each new stall, freezes when the stall ends
`timescale 1ns/1ps
module hctt_stall_timer #(
  parameter int CW = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic stall,
  input wire logic tick,
  input wire logic [4:0] limit,
  // result
  output logic expired
);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic stall_d;
  logic next_expired;

  // counter must reach one past the largest limit
  if (CW < 6) begin : g_cw_check
    $error("hctt_stall_timer: CW too small");
  end

  always_comb begin
    next_count = count;
    if (stall && !stall_d) begin
      next_count = '0;
    end else if (stall && tick && !expired) begin
      next_count = count + CW'(1);
    end
    next_expired = stall && (next_count > CW'(limit));
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      stall_d <= 1'b0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      stall_d <= stall;
      expired <= next_expired;
    end
  end

endmodule

// file: hdl/hctt_supervisor.sv
// Purpose: ends stalled host buffer accesses and raises events
// Assumes: buffer full and empty flags synchronous to ref_clk
// Notes: terminate pulse ends the stalled cycle and drops write data
`timescale 1ns/1ps

module hctt_supervisor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // host access to buffers
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic [2:0] acc_target,
  input wire logic [15:0] acc_wdata,
  // buffer state
  input wire logic jf_full,
  input wire logic lb_full,
  input wire logic lb_empty,
  input wire logic blt_full,
  input wire logic blt_empty,
  // buffer write side
  output logic buf_wr_en,
  output logic [2:0] buf_wr_target,
  output logic [15:0] buf_wr_data,
  // cycle end
  output logic acc_terminate,
  output logic acc_stalled,
  // interrupt
  output logic host_irq
);

  // ==========================================================
  // registers
  logic [15:0] host_cycle_irq_enables;
  logic [15:0] cycle_timeout_control;
  logic [15:0] irq_status;
  logic [15:0] global_ctrl;
  logic [15:0] next_enables;
  logic [15:0] next_toctrl;
  logic [15:0] next_status;
  logic [15:0] next_global;
  logic [15:0] next_rdata;
  hctt_pkg::hctt_reg_req_t rq;

  assign rq = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================
  // access supervision
  hctt_pkg::hctt_access_t acc;
  logic stall;
  logic tick;
  logic expired;
  logic immediate;
  logic [4:0] tov;
  logic terminate_now;
  logic term_latched;
  logic next_term_latched;
  logic next_terminate;
  logic next_buf_wr_en;
  logic next_irq;
  logic [15:0] events;

  function automatic logic blocked(input hctt_pkg::hctt_access_t a, input logic jff,
                                   input logic lbf, input logic lbe, input logic bf,
                                   input logic be);
    logic r;
    r = 1'b0;
    if (a.req) begin
      case (hctt_pkg::hctt_target_t'(a.target))
        hctt_pkg::HCTT_JF_WR: r = a.wr && jff;
        hctt_pkg::HCTT_LB_WR: r = a.wr && lbf;
        hctt_pkg::HCTT_LB_RD: r = !a.wr && lbe;
        hctt_pkg::HCTT_BLT_WR: r = a.wr && bf;
        hctt_pkg::HCTT_BLT_RD: r = !a.wr && be;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  assign acc = '{req: acc_req, wr: acc_wr, target: acc_target};
  // stall holds only until the terminate for this access is issued
  assign stall = blocked(acc, jf_full, lb_full, lb_empty, blt_full, blt_empty)
                 && !term_latched;
  assign immediate = cycle_timeout_control[hctt_pkg::BIT_IMMEDIATE];
  assign tov = cycle_timeout_control[hctt_pkg::TOV_MSB:0];
  assign terminate_now = stall && ((immediate && tov == hctt_pkg::TOV_ALL_ONES)
                         || expired);

  hctt_half_rate_div u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .half_rate_count_clock(tick)
  );

  hctt_stall_timer #(
    .CW(6)
  ) u_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .stall(stall),
    .tick(tick),
    .limit(tov),
    .expired(expired)
  );

  always_comb begin
    events = 16'h0000;
    if (terminate_now) begin
      if (expired) begin
        events[hctt_pkg::BIT_TIMEOUT] = 1'b1;
      end
      case (hctt_pkg::hctt_target_t'(acc.target))
        hctt_pkg::HCTT_JF_WR: events[hctt_pkg::BIT_JF_WR] = 1'b1;
        hctt_pkg::HCTT_LB_WR: events[hctt_pkg::BIT_LB_WR] = 1'b1;
        hctt_pkg::HCTT_LB_RD: events[hctt_pkg::BIT_LB_RD] = 1'b1;
        hctt_pkg::HCTT_BLT_WR: events[hctt_pkg::BIT_BLT_WR] = 1'b1;
        hctt_pkg::HCTT_BLT_RD: events[hctt_pkg::BIT_BLT_RD] = 1'b1;
        default: events = events;
      endcase
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_enables = host_cycle_irq_enables;
    next_toctrl = cycle_timeout_control;
    next_global = global_ctrl;
    next_status = irq_status;
    next_rdata = 16'h0000;
    if (rq.wr) begin
      if (rq.addr == hctt_pkg::ADDR_IRQ_ENABLES) begin
        next_enables = rq.wdata & hctt_pkg::EVENT_MASK;
      end else if (rq.addr == hctt_pkg::ADDR_TIMEOUT_CTRL) begin
        next_toctrl = rq.wdata & hctt_pkg::TOCTRL_MASK;
      end else if (rq.addr == hctt_pkg::ADDR_GLOBAL_CTRL) begin
        next_global = rq.wdata & hctt_pkg::GLOBAL_MASK;
      end else if (rq.addr == hctt_pkg::ADDR_IRQ_STATUS) begin
        next_status = irq_status & ~(rq.wdata & hctt_pkg::EVENT_MASK);
      end
    end
    next_status = next_status | events;
    if (rq.rd) begin
      if (rq.addr == hctt_pkg::ADDR_IRQ_ENABLES) begin
        next_rdata = host_cycle_irq_enables;
      end else if (rq.addr == hctt_pkg::ADDR_TIMEOUT_CTRL) begin
        next_rdata = cycle_timeout_control;
      end else if (rq.addr == hctt_pkg::ADDR_GLOBAL_CTRL) begin
        next_rdata = global_ctrl;
      end else if (rq.addr == hctt_pkg::ADDR_IRQ_STATUS) begin
        next_rdata = irq_status;
      end
    end
    next_irq = global_ctrl[hctt_pkg::BIT_HOST_IE] &&
               |(next_status & host_cycle_irq_enables);
    next_terminate = terminate_now;
    next_term_latched = term_latched;
    if (terminate_now) begin
      next_term_latched = 1'b1;
    end else if (!acc_req) begin
      next_term_latched = 1'b0;
    end
    // write passes only when accepted, never when terminated
    next_buf_wr_en = acc_req && acc_wr && !stall && !term_latched
                     && !blocked(acc, jf_full, lb_full, lb_empty, blt_full, blt_empty)
                     && !buf_wr_en;
  end

  // ==========================================================
  // registers update
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_cycle_irq_enables <= hctt_pkg::RST_IRQ_ENABLES;
      cycle_timeout_control <= hctt_pkg::RST_TIMEOUT_CTRL;
      global_ctrl <= hctt_pkg::RST_GLOBAL_CTRL;
      irq_status <= hctt_pkg::RST_IRQ_STATUS;
      reg_rdata <= 16'h0000;
      host_irq <= 1'b0;
      acc_terminate <= 1'b0;
      acc_stalled <= 1'b0;
      term_latched <= 1'b0;
      buf_wr_en <= 1'b0;
      buf_wr_target <= 3'h0;
      buf_wr_data <= 16'h0000;
    end else begin
      host_cycle_irq_enables <= next_enables;
      cycle_timeout_control <= next_toctrl;
      global_ctrl <= next_global;
      irq_status <= next_status;
      reg_rdata <= next_rdata;
      host_irq <= next_irq;
      acc_terminate <= next_terminate;
      acc_stalled <= stall;
      term_latched <= next_term_latched;
      buf_wr_en <= next_buf_wr_en;
      buf_wr_target <= acc_target;
      buf_wr_data <= acc_wdata;
    end
  end

endmodule

// file: tb/hctt_host_model.sv
// Purpose: host cpu issuing buffer accesses
// Assumes: request held until terminate or accept
// Notes: data lines toggle while released
`timescale 1ns/1ps
module hctt_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // command
  input wire logic go,
  input wire hctt_pkg::hctt_access_t cmd,
  input wire logic [15:0] wdata,
  // buffer access
  output logic acc_req,
  output logic acc_wr,
  output logic [2:0] acc_target,
  output logic [15:0] acc_wdata,
  input wire logic acc_terminate,
  input wire logic buf_wr_en,
  // result
  output logic done,
  output logic [7:0] lat
);
  // ==========================================
  // access sequencer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_req <= 1'b0;
      acc_wr <= 1'b0;
      acc_target <= 3'h0;
      acc_wdata <= 16'h0000;
      done <= 1'b0;
      lat <= 8'h00;
    end else if (acc_req) begin
      if (acc_terminate || buf_wr_en) begin
        acc_req <= 1'b0;
        done <= 1'b1;
      end else begin
        lat <= lat + 8'h01;
      end
    end else begin
      done <= 1'b0;
      if (go && !done) begin
        acc_req <= cmd.req;
        acc_wr <= cmd.wr;
        acc_target <= cmd.target;
        acc_wdata <= wdata;
        lat <= 8'h00;
      end else begin
        acc_wdata <= ~acc_wdata;
      end
    end
  end
endmodule

// file: tb/hctt_supervisor_assertions.sv
// Purpose: port checks of the supervisor
// Assumes: one clock, async high reset
// Notes: bound to every supervisor instance
`timescale 1ns/1ps
module hctt_supervisor_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // access and interrupt
  input wire logic buf_wr_en,
  input wire logic acc_terminate,
  input wire logic acc_stalled,
  input wire logic host_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // properties
  sequence stall_go;
    $rose(acc_stalled);
  endsequence
  sequence stall_out;
    acc_terminate || !acc_stalled;
  endsequence
  term_pulse_a: assert property (acc_terminate |=> !acc_terminate)
    else $error("terminate too long");
  term_stall_a: assert property (acc_terminate |-> acc_stalled)
    else $error("terminate without stall");
  term_drop_a: assert property (acc_terminate |-> !buf_wr_en)
    else $error("terminated write kept");
  stall_drop_a: assert property (acc_stalled |-> !buf_wr_en)
    else $error("stalled write kept");
  wr_pulse_a: assert property (buf_wr_en |=> !buf_wr_en)
    else $error("write pulse too long");
  stall_bound_a: assert property (stall_go |-> ##[0:68] stall_out)
    else $error("stall not ended");
  rsvd_zero_a: assert property ($past(reg_rd) &&
      $past(reg_addr) == hctt_pkg::ADDR_IRQ_ENABLES |-> !reg_rdata[0])
    else $error("reserved bit set");
  irq_cause_a: assert property ($rose(host_irq) |-> acc_terminate || $past(reg_wr, 2))
    else $error("irq without event");
  irq_clear_a: assert property ($fell(host_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq fell alone");
endmodule

bind hctt_supervisor hctt_supervisor_assertions chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .buf_wr_en(buf_wr_en), .acc_terminate(acc_terminate), .acc_stalled(acc_stalled),
  .host_irq(host_irq));

// file: tb/hctt_supervisor_tb.sv
// Purpose: bench for host cycle supervisor
// Assumes: host model drives buffer accesses
// Notes: expectations from register layout
`timescale 1ns/1ps
module hctt_supervisor_tb;
  localparam logic [15:0] EN = hctt_pkg::ADDR_IRQ_ENABLES;
  localparam logic [15:0] TO = hctt_pkg::ADDR_TIMEOUT_CTRL;
  localparam logic [15:0] ST = hctt_pkg::ADDR_IRQ_STATUS;
  localparam logic [15:0] BITS [5] = '{16'h0002, 16'h0008, 16'h0004, 16'h0020, 16'h0010};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] flags = 5'h00;
  logic go = 1'b0;
  hctt_pkg::hctt_access_t cmd = '0;
  logic [15:0] wdat = 16'h0000;
  logic [15:0] rdata, acc_wdata, bw_data, bw_seen;
  logic [2:0] acc_target, bw_tgt, tgt_seen;
  logic acc_req, acc_wr, bw_en, term, done, irq, stalled;
  logic [7:0] lat;
  int num_errors = 0;
  int total_checks = 0;
  int n_wr = 0;
  int n_stall = 0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (stalled) n_stall++;
    if (bw_en) begin
      n_wr++;
      bw_seen = bw_data;
      tgt_seen = bw_tgt;
    end
  end
  hctt_host_model host_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .cmd(cmd),
    .wdata(wdat), .acc_req(acc_req), .acc_wr(acc_wr), .acc_target(acc_target),
    .acc_wdata(acc_wdata), .acc_terminate(term), .buf_wr_en(bw_en), .done(done), .lat(lat));
  hctt_supervisor dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .acc_req(acc_req), .acc_wr(acc_wr), .acc_target(acc_target), .acc_wdata(acc_wdata),
    .jf_full(flags[0]), .lb_full(flags[1]), .lb_empty(flags[2]), .blt_full(flags[3]),
    .blt_empty(flags[4]), .buf_wr_en(bw_en), .buf_wr_target(bw_tgt), .buf_wr_data(bw_data),
    .acc_terminate(term), .acc_stalled(stalled), .host_irq(irq));
  // ==========================================
  // tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask
  task automatic access(input logic [2:0] t, input int lo, input int hi);
    cmd <= '{req: 1'b1, wr: (t != 3'd2 && t != 3'd4), target: t};
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check("latency", 16'(done && int'(lat) > lo && int'(lat) <= hi), 16'h0001);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    #500000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(EN, hctt_pkg::RST_IRQ_ENABLES);
    rd(TO, hctt_pkg::RST_TIMEOUT_CTRL);
    wr(EN, 16'hffff);
    rd(EN, 16'h803e);
    wr(TO, 16'hffff);
    rd(TO, 16'h009f);
    rd(16'h0a10, 16'h0000);
    wr(hctt_pkg::ADDR_GLOBAL_CTRL, 16'h0010);
    wr(EN, 16'h0000);
    wr(TO, 16'h009f);
    for (int t = 0; t < 5; t++) begin
      flags <= 5'(1 << t);
      access(3'(t), -1, 2);
      rd(ST, BITS[t]);
      check("irq masked", 16'(irq), 16'h0000);
      wr(EN, BITS[t]);
      rd(ST, BITS[t]);
      check("irq on", 16'(irq), 16'h0001);
      wr(ST, 16'h803e ^ BITS[t]);
      rd(ST, BITS[t]);
      wr(ST, BITS[t]);
      rd(ST, 16'h0000);
      check("irq off", 16'(irq), 16'h0000);
      wr(EN, 16'h0000);
    end
    check("dropped", 16'(n_wr), 16'h0000);
    check("stalled", 16'(n_stall), 16'h0005);
    flags <= 5'h01;
    wr(EN, 16'h8000);
    wr(TO, 16'h0003);
    repeat (2) begin
      access(3'd0, 6, 12);
      rd(ST, 16'h8002);
      check("irq timeout", 16'(irq), 16'h0001);
      wr(ST, 16'h8002);
    end
    wr(TO, 16'h001f);
    access(3'd0, 62, 68);
    rd(ST, 16'h8002);
    flags <= 5'h00;
    wdat <= 16'ha5c3;
    access(3'd3, -1, 3);
    check("data", bw_seen, 16'ha5c3);
    check("target", 16'(tgt_seen), 16'h0003);
    check("writes", 16'(n_wr), 16'h0001);
    conclude();
  end
endmodule
